// ---- design/term_io_pkg.sv ----
// package: register map, codes, timing and carriers for the terminal io stage
package term_io_pkg;

  // ---------------------------------------------------------------
  // bus and data widths
  // ---------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam int NUM_DIN = 6;
  localparam int NUM_IN = 8;
  localparam int NUM_DOUT = 3;
  localparam int ADC_W = 10;
  localparam int FC_W = 7;

  // ---------------------------------------------------------------
  // word offsets (byte address = index * 4)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] REG_FC_LO = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FC_HI = 4'h2;
  localparam logic [ADDR_W-1:0] REG_ROUTE = 4'h3;
  localparam logic [ADDR_W-1:0] REG_DOUT_SRC = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] REG_ADC_CFG = 4'h6;
  localparam logic [ADDR_W-1:0] REG_ADC0 = 4'h7;
  localparam logic [ADDR_W-1:0] REG_FIRST_ANALOG_INPUT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h9;
  localparam logic [DATA_W-1:0] UNMAPPED_VAL = 32'hdead_beef;

  // ctrl fields
  localparam int CTRL_POL_BIT = 0;   // 1: 24 V is logical one
  localparam int CTRL_DEB_LSB = 1;   // 2-bit debounce select
  localparam int CTRL_SRC_LSB = 4;   // 2-bit command source
  localparam logic [1:0] CMD_SRC_TERMINAL = 2'h2;

  // ---------------------------------------------------------------
  // input function codes
  // ---------------------------------------------------------------
  localparam logic [FC_W-1:0] FC_OFF = 7'h00;
  localparam logic [FC_W-1:0] FC_RUN = 7'h01;
  localparam logic [FC_W-1:0] FC_RUN_REV = 7'h02;
  localparam logic [FC_W-1:0] FC_COAST = 7'h03;
  localparam logic [FC_W-1:0] FC_FAST = 7'h04;
  localparam logic [FC_W-1:0] FC_ACK = 7'h09;
  localparam logic [FC_W-1:0] FC_INCH_CW = 7'h0a;
  localparam logic [FC_W-1:0] FC_INCH_CCW = 7'h0b;
  localparam logic [FC_W-1:0] FC_REVERSE = 7'h0c;
  localparam logic [FC_W-1:0] FC_MOT_UP = 7'h0d;
  localparam logic [FC_W-1:0] FC_MOT_DN = 7'h0e;
  localparam logic [FC_W-1:0] FC_FIX_DIR = 7'h0f;
  localparam logic [FC_W-1:0] FC_FIX_RUN = 7'h10;
  localparam logic [FC_W-1:0] FC_FIX_BIN = 7'h11;
  localparam logic [FC_W-1:0] FC_DC_BRAKE = 7'h19;
  localparam logic [FC_W-1:0] FC_EXT_TRIP = 7'h1d;
  localparam logic [FC_W-1:0] FC_NO_ADD = 7'h21;
  localparam logic [FC_W-1:0] FC_ROUTE = 7'h63;

  // routing source parameter numbers (7 bits kept)
  localparam logic [6:0] SRC_INPUT_STATE = 7'h52; // 722 mod 128 tag value
  localparam logic [6:0] SRC_DRIVE_STATUS = 7'h34; // status word 52

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SCAN_US = 1000;
  localparam int SCAN_CYC = SCAN_US * CLK_MHZ;
  localparam int DEB_STAGE_W = 2;
  localparam int FILT_SHIFT_W = 3;
  localparam logic [ADC_W-1:0] ADC_DIG_HIGH = 10'h18f; // about 3.9 V
  localparam logic [ADC_W-1:0] ADC_DIG_LOW = 10'h0ae;  // about 1.7 V

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       run;
    logic       run_rev;
    logic       coast_stop_n;
    logic       fast_stop_n;
    logic       fault_ack;
    logic       inch_cw;
    logic       inch_ccw;
    logic       reverse;
    logic       mot_up;
    logic       mot_dn;
    logic [2:0] fix_sel;
    logic       dc_brake;
    logic       ext_trip;
    logic       no_add_sp;
  } drive_cmd_t;

  typedef struct packed {
    logic [6:0] param;
    logic [3:0] bit_no;
  } route_src_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

  // status bit selection shared by routing and outputs
  function automatic logic pick_bit(input route_src_t s,
                                    input logic [15:0] in_word,
                                    input logic [15:0] stat_word);
    logic r;
    r = 1'b0;
    if (s.param == SRC_INPUT_STATE) r = in_word[s.bit_no];
    else if (s.param == SRC_DRIVE_STATUS) r = stat_word[s.bit_no];
    return r;
  endfunction

endpackage

// ---- design/input_debounce.sv ----
// one debounce channel: logic level must hold for n scans
`timescale 1ns/1ps
`default_nettype none
module input_debounce
  import term_io_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // scan tick and selection
  input  wire logic                   tick,
  input  wire logic [DEB_STAGE_W-1:0] sel,
  // level in and filtered level out
  input  wire logic                   din,
  output logic                        dout
);

  logic [2:0] cnt_q, cnt_d;
  logic       out_q, out_d;
  logic [2:0] need;

  // count scans for which input disagrees with output
  always_comb begin
    need = {1'b0, sel} << 1;
    cnt_d = cnt_q;
    out_d = out_q;
    if (tick) begin
      if (din == out_q) begin
        cnt_d = 3'h0;
      end else if (cnt_q >= need) begin
        out_d = din;
        cnt_d = 3'h0;
      end else begin
        cnt_d = cnt_q + 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign dout = out_q;

endmodule
`default_nettype wire

// ---- design/term_io.sv ----
// terminal input/output mapping stage with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
module term_io
  import term_io_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CYC
)(
  // clock and reset
  input  wire logic                CLK_SYS,
  input  wire logic                RST_N,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]   AVS_ADDRESS,
  input  wire logic                AVS_READ,
  input  wire logic                AVS_WRITE,
  input  wire logic [DATA_W-1:0]   AVS_WRITEDATA,
  output logic [DATA_W-1:0]        AVS_READDATA,
  output logic                     AVS_WAITREQUEST,
  // terminal pins and converter samples
  input  wire logic [NUM_DIN-1:0]  DIG_IN,
  input  wire logic [ADC_W-1:0]    ADC0_IN,
  input  wire logic [ADC_W-1:0]    FIRST_ANALOG_INPUT_IN,
  input  wire logic                ADC0_NEG,
  // drive status word and results
  input  wire logic [15:0]         DRIVE_STATUS,
  output logic [NUM_DOUT-1:0]      DIG_OUT,
  output drive_cmd_t               DRIVE_CMD,
  output logic                     TERMINAL_ACTIVE
);

  // ---------------------------------------------------------------
  // synchronisers
  // ---------------------------------------------------------------
  logic [NUM_DIN-1:0] din_s1_q, din_s2_q;
  logic [ADC_W-1:0]   a0_s1_q, a0_s2_q, a1_s1_q, a1_s2_q;
  logic               neg_s1_q, neg_s2_q;

  // two flops on every pin input
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      din_s1_q <= '0;
      din_s2_q <= '0;
      a0_s1_q <= '0;
      a0_s2_q <= '0;
      a1_s1_q <= '0;
      a1_s2_q <= '0;
      neg_s1_q <= 1'b0;
      neg_s2_q <= 1'b0;
    end else begin
      din_s1_q <= DIG_IN;
      din_s2_q <= din_s1_q;
      a0_s1_q <= ADC0_IN;
      a0_s2_q <= a0_s1_q;
      a1_s1_q <= FIRST_ANALOG_INPUT_IN;
      a1_s2_q <= a1_s1_q;
      neg_s1_q <= ADC0_NEG;
      neg_s2_q <= neg_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers and bus slave
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] ctrl_q, ctrl_d, fc_lo_q, fc_lo_d, fc_hi_q, fc_hi_d;
  logic [DATA_W-1:0] route_q, route_d, dsrc_q, dsrc_d, acfg_q, acfg_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              wait_q, wait_d;
  bus_state_t        bst_q, bst_d;
  logic [NUM_IN-1:0] state_q;
  logic [ADC_W:0]    a0_out_q, a1_out_q;
  drive_cmd_t        cmd_q;

  // accept one request, answer with waitrequest low one cycle later
  always_comb begin
    bst_d = bst_q;
    wait_d = 1'b1;
    rdata_d = rdata_q;
    ctrl_d = ctrl_q;
    fc_lo_d = fc_lo_q;
    fc_hi_d = fc_hi_q;
    route_d = route_q;
    dsrc_d = dsrc_q;
    acfg_d = acfg_q;
    case (bst_q)
      BUS_IDLE: begin
        if (AVS_READ || AVS_WRITE) begin
          bst_d = BUS_ACK;
          wait_d = 1'b0;
          if (AVS_WRITE) begin
            case (AVS_ADDRESS)
              REG_CTRL:     ctrl_d = AVS_WRITEDATA;
              REG_FC_LO:    fc_lo_d = AVS_WRITEDATA;
              REG_FC_HI:    fc_hi_d = AVS_WRITEDATA;
              REG_ROUTE:    route_d = AVS_WRITEDATA;
              REG_DOUT_SRC: dsrc_d = AVS_WRITEDATA;
              REG_ADC_CFG:  acfg_d = AVS_WRITEDATA;
              default:      ;
            endcase
            rdata_d = '0;
          end else begin
            case (AVS_ADDRESS)
              REG_CTRL:     rdata_d = ctrl_q;
              REG_FC_LO:    rdata_d = fc_lo_q;
              REG_FC_HI:    rdata_d = fc_hi_q;
              REG_ROUTE:    rdata_d = route_q;
              REG_DOUT_SRC: rdata_d = dsrc_q;
              REG_STATUS:   rdata_d = {24'h0, state_q};
              REG_ADC_CFG:  rdata_d = acfg_q;
              REG_ADC0:     rdata_d = {{21{a0_out_q[ADC_W]}}, a0_out_q};
              REG_FIRST_ANALOG_INPUT:     rdata_d = {21'h0, a1_out_q};
              REG_CMD:      rdata_d = {16'h0, cmd_q};
              default:      rdata_d = UNMAPPED_VAL;
            endcase
          end
        end
      end
      BUS_ACK: bst_d = BUS_IDLE;
      default: bst_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      bst_q <= BUS_IDLE;
      wait_q <= 1'b1;
      rdata_q <= '0;
      ctrl_q <= '0;
      fc_lo_q <= '0;
      fc_hi_q <= '0;
      route_q <= '0;
      dsrc_q <= '0;
      acfg_q <= '0;
    end else begin
      bst_q <= bst_d;
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      ctrl_q <= ctrl_d;
      fc_lo_q <= fc_lo_d;
      fc_hi_q <= fc_hi_d;
      route_q <= route_d;
      dsrc_q <= dsrc_d;
      acfg_q <= acfg_d;
    end
  end

  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = wait_q;

  // ---------------------------------------------------------------
  // scan tick
  // ---------------------------------------------------------------
  logic [31:0] scan_q, scan_d;
  logic        tick;

  // fixed scan period for capture and output update
  always_comb begin
    tick = (scan_q == 32'(SCAN_CYCLES - 1));
    scan_d = tick ? 32'h0 : scan_q + 32'h1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) scan_q <= '0;
    else scan_q <= scan_d;
  end

  // ---------------------------------------------------------------
  // input conditioning
  // ---------------------------------------------------------------
  logic [NUM_IN-1:0] raw;
  logic [NUM_IN-1:0] deb;
  logic [ADC_W:0]    a0_f_q, a0_f_d, a1_f_q, a1_f_d;

  // polarity on the six pins, thresholds on analog pair
  always_comb begin
    raw[NUM_DIN-1:0] = ctrl_q[CTRL_POL_BIT] ? din_s2_q : ~din_s2_q;
    raw[NUM_DIN] = a0_s2_q > ADC_DIG_HIGH;
    raw[NUM_DIN+1] = a1_s2_q > ADC_DIG_HIGH;
  end

  // one debounce channel per logical input
  for (genvar i = 0; i < NUM_IN; i++) begin : g_deb
    input_debounce u_deb (
      .clk  (CLK_SYS),
      .rst_n(RST_N),
      .tick (tick),
      .sel  (ctrl_q[CTRL_DEB_LSB +: DEB_STAGE_W]),
      .din  (raw[i]),
      .dout (deb[i])
    );
  end

  // analog: low-pass, scale, dead zone each scan
  logic [ADC_W:0] a0_in, a1_in, a0_sc, a1_sc;
  logic [2:0]     shift0, shift1;
  logic [ADC_W:0] dz;
  always_comb begin
    shift0 = acfg_q[2:0];
    shift1 = acfg_q[5:3];
    dz = {1'b0, acfg_q[17:8]};
    // bipolar sign only honoured on first input
    a0_in = neg_s2_q ? -{1'b0, a0_s2_q} : {1'b0, a0_s2_q};
    a1_in = {1'b0, a1_s2_q};
    a0_f_d = a0_f_q;
    a1_f_d = a1_f_q;
    if (tick) begin
      a0_f_d = a0_f_q + 11'($signed(a0_in - a0_f_q) >>> shift0);
      a1_f_d = a1_f_q + ((a1_in - a1_f_q) >> shift1);
    end
    a0_sc = acfg_q[6] ? (a0_f_q <<< 1) : a0_f_q;
    a1_sc = acfg_q[7] ? (a1_f_q << 1) : a1_f_q;
    if ($signed(a0_sc) < $signed(dz) && $signed(a0_sc) > -$signed(dz))
      a0_sc = '0;
    if (a1_sc < dz) a1_sc = '0;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      a0_f_q <= '0;
      a1_f_q <= '0;
      a0_out_q <= '0;
      a1_out_q <= '0;
      state_q <= '0;
    end else begin
      a0_f_q <= a0_f_d;
      a1_f_q <= a1_f_d;
      a0_out_q <= a0_sc;
      a1_out_q <= a1_sc;
      if (tick) state_q <= deb;
    end
  end

  // ---------------------------------------------------------------
  // function code mapping and routing
  // ---------------------------------------------------------------
  drive_cmd_t        cmd_d;
  logic [NUM_DOUT-1:0] dout_q, dout_d;
  logic              term_q, term_d;
  logic [FC_W-1:0]   fc;
  logic [15:0]       in_word;
  logic [2:0]        fix_n;

  always_comb begin
    cmd_d = '0;
    cmd_d.coast_stop_n = 1'b1;
    cmd_d.fast_stop_n = 1'b1;
    fix_n = 3'h0;
    fc = '0;
    in_word = {8'h0, state_q};
    term_d = (ctrl_q[CTRL_SRC_LSB +: 2] == CMD_SRC_TERMINAL);
    for (int i = 0; i < NUM_IN; i++) begin
      fc = (i < 4) ? fc_lo_q[i*8 +: FC_W] : fc_hi_q[(i-4)*8 +: FC_W];
      if (state_q[i]) begin
        case (fc)
          FC_OFF:      ;
          FC_RUN:      cmd_d.run = 1'b1;
          FC_RUN_REV: begin
            cmd_d.run = 1'b1;
            cmd_d.run_rev = 1'b1;
          end
          FC_COAST:    cmd_d.coast_stop_n = 1'b0;
          FC_FAST:     cmd_d.fast_stop_n = 1'b0;
          FC_ACK:      cmd_d.fault_ack = 1'b1;
          FC_INCH_CW:  cmd_d.inch_cw = 1'b1;
          FC_INCH_CCW: cmd_d.inch_ccw = 1'b1;
          FC_REVERSE:  cmd_d.reverse = 1'b1;
          FC_MOT_UP:   cmd_d.mot_up = 1'b1;
          FC_MOT_DN:   cmd_d.mot_dn = 1'b1;
          FC_FIX_DIR:  fix_n = 3'(i + 1);
          FC_FIX_RUN: begin
            fix_n = 3'(i + 1);
            cmd_d.run = 1'b1;
          end
          FC_FIX_BIN: begin
            fix_n = fix_n | (3'h1 << (i % 3));
            cmd_d.run = 1'b1;
          end
          FC_DC_BRAKE: cmd_d.dc_brake = 1'b1;
          FC_EXT_TRIP: cmd_d.ext_trip = 1'b1;
          FC_NO_ADD:   cmd_d.no_add_sp = 1'b1;
          default:     ;
        endcase
      end
    end
    cmd_d.fix_sel = fix_n;
    // free routing feeds run command from a chosen bit of the input state or drive status word
    if (route_q[15] && pick_bit(route_src_t'(route_q[10:0]), in_word,
                                DRIVE_STATUS)) begin
      cmd_d.run = 1'b1;
    end
    if (!term_d) begin
      cmd_d = '0;
      cmd_d.coast_stop_n = 1'b1;
      cmd_d.fast_stop_n = 1'b1;
    end
    for (int k = 0; k < NUM_DOUT; k++) begin
      dout_d[k] = pick_bit(route_src_t'(11'({1'b0, dsrc_q} >> k*11)), in_word,
                           DRIVE_STATUS);
    end
  end

  // command and digital outputs refreshed only on the scan tick, terminal flag every cycle
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cmd_q <= '0;
      dout_q <= '0;
      term_q <= 1'b0;
    end else begin
      term_q <= term_d;
      if (tick) begin
        cmd_q <= cmd_d;
        dout_q <= dout_d;
      end
    end
  end

  assign DIG_OUT = dout_q;
  assign DRIVE_CMD = cmd_q;
  assign TERMINAL_ACTIVE = term_q;

endmodule
`default_nettype wire

// ---- sim/term_io_asserts.sv ----
// checker of bus timing and scan behaviour at the stage's ports
`timescale 1ns/1ps
`default_nettype none
module term_io_asserts
  import term_io_pkg::*;
#(
  parameter int SCAN_CYCLES = SCAN_CYC
)(
  // clock and reset
  input wire logic                CLK_SYS,
  input wire logic                RST_N,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0]   AVS_ADDRESS,
  input wire logic                AVS_READ,
  input wire logic                AVS_WRITE,
  input wire logic [DATA_W-1:0]   AVS_WRITEDATA,
  input wire logic [DATA_W-1:0]   AVS_READDATA,
  input wire logic                AVS_WAITREQUEST,
  // results
  input wire logic [NUM_DOUT-1:0] DIG_OUT,
  input wire drive_cmd_t          DRIVE_CMD,
  input wire logic                TERMINAL_ACTIVE
);
  logic [NUM_DOUT-1:0] dout_q, dout_d;
  logic [31:0]         quiet_q, quiet_d;
  logic [31:0]         off_q, off_d;

  // ---------------------------------------------------------------
  // helper counters
  // ---------------------------------------------------------------
  // cycles since outputs moved, cycles without terminal control
  always_comb begin
    dout_d = DIG_OUT;
    quiet_d = (DIG_OUT != dout_q) ? 32'h0 : quiet_q + {31'h0, ~&quiet_q};
    off_d = TERMINAL_ACTIVE ? 32'h0 : off_q + {31'h0, ~&off_q};
    if (!RST_N) begin
      quiet_d = 32'hffff_ffff;
      off_d = 32'h0;
    end
  end
  always_ff @(posedge CLK_SYS) begin
    dout_q <= dout_d;
    quiet_q <= quiet_d;
    off_q <= off_d;
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence req_waiting;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence rd_unmapped;
    AVS_READ && AVS_WAITREQUEST && (AVS_ADDRESS > REG_CMD);
  endsequence
  sequence ctrl_written;
    AVS_WRITE && !AVS_WAITREQUEST && (AVS_ADDRESS == REG_CTRL) ##2 1'b1;
  endsequence

  AST_ANSWER_NEXT: assert property (req_waiting |=> !AVS_WAITREQUEST)
    else $error("request not answered in one cycle");
  AST_ANSWER_PULSE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  AST_NO_STRAY: assert property (
    !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST)
    else $error("answer without request");
  AST_UNMAPPED: assert property (rd_unmapped |=> AVS_READDATA == UNMAPPED_VAL)
    else $error("unmapped read value wrong");
  AST_READ_HOLD: assert property (
    AVS_WAITREQUEST && $past(AVS_WAITREQUEST) |-> $stable(AVS_READDATA))
    else $error("read data moved between answers");
  AST_TERM_SRC: assert property (
    ctrl_written |-> TERMINAL_ACTIVE ==
      ($past(AVS_WRITEDATA[CTRL_SRC_LSB +: 2], 2) == CMD_SRC_TERMINAL))
    else $error("terminal source flag wrong");
  AST_CMD_GATED: assert property (
    off_q > 32'(SCAN_CYCLES + 1) |-> !DRIVE_CMD.run && !DRIVE_CMD.run_rev
      && (DRIVE_CMD.fix_sel == 3'h0))
    else $error("commands given while terminals not in control");
  AST_DOUT_SCAN: assert property (
    $changed(DIG_OUT) |-> quiet_q >= 32'(SCAN_CYCLES - 1))
    else $error("digital outputs moved between scans");
  AST_RESET_QUIET: assert property (disable iff (1'b0)
    !RST_N |=> AVS_WAITREQUEST && (DIG_OUT == '0) && !TERMINAL_ACTIVE)
    else $error("outputs not cleared in reset");
endmodule

bind term_io term_io_asserts #(.SCAN_CYCLES(SCAN_CYCLES)) term_io_asserts_inst(
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .DIG_OUT(DIG_OUT), .DRIVE_CMD(DRIVE_CMD), .TERMINAL_ACTIVE(TERMINAL_ACTIVE)
);
`default_nettype wire

// ---- sim/term_io_field.sv ----
// model of the switches and sensors wired to the terminal strip
`timescale 1ns/1ps
`default_nettype none
module term_io_field
  import term_io_pkg::*;
(
  // logical states wanted, contact wiring and chatter
  input  wire logic [NUM_IN-1:0] level,
  input  wire logic              hi_is_one,
  input  wire logic              chatter,
  // pins and converter samples toward the stage
  output logic [NUM_DIN-1:0]     pins,
  output logic [ADC_W-1:0]       adc0,
  output logic [ADC_W-1:0]       first_analog_input,
  output logic                   adc0_neg
);
  // contacts to 24 v or 0 v; chatter flips all six at once
  always_comb begin
    pins = level[NUM_DIN-1:0] ^ {NUM_DIN{~hi_is_one ^ chatter}};
  end
  // voltage sources just past the thresholds, switch set to voltage
  always_comb begin
    adc0 = level[6] ? ADC_DIG_HIGH + 10'h001 : ADC_DIG_LOW - 10'h001;
    first_analog_input = level[7] ? ADC_DIG_HIGH + 10'h001 : ADC_DIG_LOW - 10'h001;
    adc0_neg = 1'b0;
  end
endmodule
`default_nettype wire

// ---- sim/term_io_tb.sv ----
// self-checking bench for the terminal io stage
`timescale 1ns/1ps
`default_nettype none
module term_io_tb
  import term_io_pkg::*;
;
  localparam int SCAN = 8;
  localparam int SETTLE = 16 * SCAN;
  localparam int LIMIT = 20000;

  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic                clk_sys = 1'b0;
  logic                rst_n;
  logic [ADDR_W-1:0]   avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [DATA_W-1:0]   avs_writedata;
  logic [DATA_W-1:0]   avs_readdata;
  logic                avs_waitrequest;
  logic [NUM_DIN-1:0]  dig_in;
  logic [ADC_W-1:0]    adc0_in;
  logic [ADC_W-1:0]    first_analog_input_in;
  logic                adc0_neg;
  logic [15:0]         drive_status;
  logic [NUM_DOUT-1:0] dig_out;
  drive_cmd_t          drive_cmd;
  drive_cmd_t          on_cmd;
  logic                terminal_active;
  logic [NUM_IN-1:0]   level;
  logic                hi_is_one;
  logic                chatter;
  logic [31:0]         seed;
  logic [31:0]         rd;
  logic [31:0]         exp_w;
  logic [63:0]         fcw;
  logic [32:0]         dsrc;
  int                  fail_count = 0;
  int                  num_checks = 0;
  int                  cyc = 0;
  int                  idx;
  logic [FC_W-1:0]     codes [18] = '{FC_OFF, FC_RUN, FC_RUN_REV, FC_COAST,
    FC_FAST, FC_ACK, FC_INCH_CW, FC_INCH_CCW, FC_REVERSE, FC_MOT_UP,
    FC_MOT_DN, FC_FIX_DIR, FC_FIX_RUN, FC_FIX_BIN, FC_DC_BRAKE, FC_EXT_TRIP,
    FC_NO_ADD, FC_ROUTE};

  // ---------------------------------------------------------------
  // design and field model
  // ---------------------------------------------------------------
  term_io #(.SCAN_CYCLES(SCAN)) term_io_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest),
    .DIG_IN(dig_in), .ADC0_IN(adc0_in), .FIRST_ANALOG_INPUT_IN(first_analog_input_in),
    .ADC0_NEG(adc0_neg), .DRIVE_STATUS(drive_status), .DIG_OUT(dig_out),
    .DRIVE_CMD(drive_cmd), .TERMINAL_ACTIVE(terminal_active));
  term_io_field term_io_field_inst (
    .level(level), .hi_is_one(hi_is_one), .chatter(chatter), .pins(dig_in),
    .adc0(adc0_in), .first_analog_input(first_analog_input_in), .adc0_neg(adc0_neg));

  // clock and hang guard
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      fail_count++;
      final_report;
    end
  end

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // command bits an active input with this code should move
  function automatic drive_cmd_t role(input logic [FC_W-1:0] fc, input int i);
    drive_cmd_t m;
    m = '0;
    case (fc)
      FC_RUN: m.run = 1'b1;
      FC_RUN_REV: {m.run, m.run_rev} = 2'h3;
      FC_COAST: m.coast_stop_n = 1'b1;
      FC_FAST: m.fast_stop_n = 1'b1;
      FC_ACK: m.fault_ack = 1'b1;
      FC_INCH_CW: m.inch_cw = 1'b1;
      FC_INCH_CCW: m.inch_ccw = 1'b1;
      FC_REVERSE: m.reverse = 1'b1;
      FC_MOT_UP: m.mot_up = 1'b1;
      FC_MOT_DN: m.mot_dn = 1'b1;
      FC_FIX_DIR: m.fix_sel = 3'(i + 1);
      FC_FIX_RUN: m = '{run: 1'b1, fix_sel: 3'(i + 1), default: 1'b0};
      FC_FIX_BIN: m = '{run: 1'b1, fix_sel: 3'(1 << (i % 3)), default: 1'b0};
      FC_DC_BRAKE: m.dc_brake = 1'b1;
      FC_EXT_TRIP: m.ext_trip = 1'b1;
      FC_NO_ADD: m.no_add_sp = 1'b1;
      default: m = '0;
    endcase
    return m;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // one avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk_sys);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
    check({31'h0, avs_waitrequest}, 32'h1);
  endtask
  task automatic final_report;
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    drive_status = '0;
    level = '0;
    hi_is_one = 1'b1;
    chatter = 1'b0;
    seed = 32'h977e0188;
    settle(5);
    rst_n <= 1'b1;
    settle(1);
    // unmapped place: fixed word, writes ignored
    bus(1'b1, REG_CTRL, 32'h0000_0025);
    bus(1'b1, 4'hf, 32'hffff_ffff);
    bus(1'b0, 4'hf, 32'h0);
    check(rd, UNMAPPED_VAL);
    bus(1'b0, REG_CTRL, 32'h0);
    check(rd & 32'h37, 32'h25);
    // random states, both wirings, then the polarity turned round
    repeat (6) begin
      seed = lfsr(seed);
      level <= seed[7:0];
      hi_is_one <= seed[8];
      bus(1'b1, REG_CTRL, {26'h0, 2'h2, 1'b0, seed[10:9], seed[8]});
      settle(SETTLE);
      bus(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[7:0]), 32'(seed[7:0]));
      bus(1'b1, REG_CTRL, {26'h0, 2'h2, 1'b0, seed[10:9], ~seed[8]});
      settle(SETTLE);
      bus(1'b0, REG_STATUS, 32'h0);
      check(32'(rd[7:0]), 32'(seed[7:0] ^ 8'h3f));
    end
    // short chatter: rejected by the longest filter, seen by the shortest
    for (int s = 3; s >= 0; s -= 3) begin
      hi_is_one <= 1'b1;
      bus(1'b1, REG_CTRL, {26'h0, 2'h2, 1'b0, 2'(s), 1'b1});
      settle(SETTLE);
      chatter <= 1'b1;
      settle(4 * SCAN);
      bus(1'b0, REG_STATUS, 32'h0);
      chatter <= 1'b0;
      check(32'(rd[7:0]), 32'((s == 3) ? level : level ^ 8'h3f));
    end
    // every role code on a random input, seen as the change it causes
    bus(1'b1, REG_CTRL, 32'h0000_0021);
    bus(1'b1, REG_ROUTE, 32'h0);
    foreach (codes[k]) begin
      seed = lfsr(seed);
      idx = int'(seed[7:0]) % 7;
      fcw = 64'(codes[k]) << (8 * idx);
      bus(1'b1, REG_FC_LO, fcw[31:0]);
      bus(1'b1, REG_FC_HI, fcw[63:32]);
      level <= 8'h1 << idx;
      settle(SETTLE);
      on_cmd = drive_cmd;
      level <= 8'h0;
      settle(SETTLE);
      exp_w = 32'(role(codes[k], idx));
      check(32'(on_cmd ^ drive_cmd), exp_w);
      if (codes[k] == FC_RUN) check(32'(on_cmd.run), 32'h1);
    end
    // freed input drives run through the route, only under terminal control
    idx = int'(seed[15:8]) % 8;
    fcw = 64'(FC_ROUTE) << (8 * idx);
    bus(1'b1, REG_FC_LO, fcw[31:0]);
    bus(1'b1, REG_FC_HI, fcw[63:32]);
    bus(1'b1, REG_ROUTE, 32'h8000 | (32'(SRC_INPUT_STATE) << 4) | 32'(idx));
    level <= 8'h1 << idx;
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, REG_CTRL, {26'h0, 2'(s ^ 1), 4'h1});
      settle(SETTLE);
      check(32'(drive_cmd.run), 32'((s ^ 1) == 2));
      check(32'(terminal_active), 32'((s ^ 1) == 2));
    end
    level <= 8'h0;
    settle(SETTLE);
    check(32'(drive_cmd.run), 32'h0);
    // outputs follow chosen status bits and input states
    repeat (4) begin
      seed = lfsr(seed);
      drive_status <= seed[31:16];
      level <= seed[15:8];
      dsrc = {SRC_DRIVE_STATUS, seed[10:7], SRC_INPUT_STATE, 1'b0, seed[2:0],
              SRC_DRIVE_STATUS, seed[6:3]};
      bus(1'b1, REG_DOUT_SRC, dsrc[31:0]);
      settle(SETTLE);
      exp_w = {29'h0, seed[16 + seed[10:7]], seed[8 + seed[2:0]],
               seed[16 + seed[6:3]]};
      check(32'(dig_out), exp_w);
    end
    // second reset in mid-run
    rst_n <= 1'b0;
    settle(5);
    check(32'(terminal_active), 32'h0);
    check(32'(avs_waitrequest), 32'h1);
    rst_n <= 1'b1;
    settle(2);
    final_report;
  end
endmodule
`default_nettype wire
